// file: logic/mie_pkg.sv
`default_nettype none
package mie_pkg;

  // Datapath and program counter widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PC_W    = 12;

  // System clock: 125 MHz, period in ns
  localparam int unsigned CLK_PERIOD_NS = 8;

  // One instruction cycle spans this many system clocks
  localparam int unsigned CLKS_PER_CYCLE = 4;
  localparam int unsigned PHASE_W        = $clog2(CLKS_PER_CYCLE);

  // Decimal adjust constants
  localparam logic [3:0] BCD_LIMIT  = 4'h9;
  localparam logic [3:0] BCD_ADJUST = 4'h6;

  // Reset values of the status state
  localparam logic       ZERO_RST   = 1'b0;
  localparam logic       CARRY_RST  = 1'b0;
  localparam logic       TMO_RST    = 1'b0;
  localparam logic       PDN_RST    = 1'b0;
  localparam logic       GIE_RST    = 1'b0;
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [7:0] BYTE_ONE   = 8'h01;

  // Data address of the low program counter byte (plain default)
  localparam logic [7:0] PCL_ADDR_DEF = 8'h06;

  // Decoded operations handed over by the fetch/decode path
  typedef enum logic [4:0] {
    MIE_OP_IDLE,
    MIE_OP_PRECLEAR_A,
    MIE_OP_PRECLEAR_B,
    MIE_OP_INVERT_MEM,
    MIE_OP_INVERT_TO_ACC,
    MIE_OP_BCD_ADJUST,
    MIE_OP_MINUS_ONE_MEM,
    MIE_OP_MINUS_ONE_TO_ACC,
    MIE_OP_PLUS_ONE_MEM,
    MIE_OP_PLUS_ONE_TO_ACC,
    MIE_OP_SLEEP,
    MIE_OP_DIRECT_BRANCH,
    MIE_OP_COPY_IMM,
    MIE_OP_COPY_MEM_TO_ACC,
    MIE_OP_COPY_ACC_TO_MEM,
    MIE_OP_UNION_MEM,
    MIE_OP_UNION_IMM,
    MIE_OP_UNION_TO_MEM,
    MIE_OP_SUBROUTINE_EXIT,
    MIE_OP_SUBROUTINE_EXIT_VAL,
    MIE_OP_INTERRUPT_EXIT,
    MIE_OP_ROTATE_LEFT,
    MIE_OP_ROTATE_LEFT_TO_ACC
  } mie_op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    MIE_ST_READY,
    MIE_ST_EXEC,
    MIE_ST_EXTRA,
    MIE_ST_SLEEP
  } mie_state_t;

endpackage
`default_nettype wire

// file: logic/mie_phase_div.sv
`timescale 1ns/1ps
`default_nettype none
module mie_phase_div #(
  parameter int unsigned CLKS = mie_pkg::CLKS_PER_CYCLE
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      cycle_end
);

  localparam int unsigned CW = (CLKS > 1) ? $clog2(CLKS) : 1;
  localparam logic [CW-1:0] LAST = CW'(CLKS - 1);

  logic [CW-1:0] phase_r;
  logic [CW-1:0] phase_nxt;

  //////////////////////////////////////////////////////////////////////////
  // Phase count; idle restarts it so each cycle begins on phase zero
  always_comb begin
    phase_nxt = phase_r;
    if (!run) begin
      phase_nxt = '0;
    end else if (phase_r == LAST) begin
      phase_nxt = '0;
    end else begin
      phase_nxt = phase_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // One-cycle enable at the last system clock of an instruction cycle
  assign cycle_end = run && (phase_r == LAST);

endmodule
`default_nettype wire

// file: logic/mie_alu.sv
`timescale 1ns/1ps
`default_nettype none
module mie_alu (
  input  wire logic            op_is_valid,
  input  wire mie_pkg::mie_op_t op,
  input  wire logic [7:0]      acc,
  input  wire logic [7:0]      mem,
  input  wire logic [7:0]      imm,
  input  wire logic            half_carry,
  input  wire logic            carry,
  output logic [7:0]           result,
  output logic                 result_zero,
  output logic                 carry_out
);

  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic       nib_carry;

  //////////////////////////////////////////////////////////////////////////
  // Decimal adjust; nibble carry only when adjusted without half carry
  always_comb begin
    lo_sum    = {1'b0, acc[3:0]};
    nib_carry = 1'b0;
    if ((acc[3:0] > mie_pkg::BCD_LIMIT) || half_carry) begin
      lo_sum    = {1'b0, acc[3:0]} + {1'b0, mie_pkg::BCD_ADJUST};
      nib_carry = !half_carry;
    end
    hi_sum    = {1'b0, acc[7:4]} + {4'b0000, nib_carry};
    carry_out = carry;
    if ((hi_sum > {1'b0, mie_pkg::BCD_LIMIT}) || carry) begin
      hi_sum    = hi_sum + {1'b0, mie_pkg::BCD_ADJUST};
      carry_out = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result byte per operation
  always_comb begin
    result = acc;
    unique case (op)
      mie_pkg::MIE_OP_INVERT_MEM,
      mie_pkg::MIE_OP_INVERT_TO_ACC:     result = ~mem;
      mie_pkg::MIE_OP_BCD_ADJUST:        result = {hi_sum[3:0], lo_sum[3:0]};
      mie_pkg::MIE_OP_MINUS_ONE_MEM,
      mie_pkg::MIE_OP_MINUS_ONE_TO_ACC:  result = mem - mie_pkg::BYTE_ONE;
      mie_pkg::MIE_OP_PLUS_ONE_MEM,
      mie_pkg::MIE_OP_PLUS_ONE_TO_ACC:   result = mem + mie_pkg::BYTE_ONE;
      mie_pkg::MIE_OP_COPY_IMM,
      mie_pkg::MIE_OP_SUBROUTINE_EXIT_VAL: result = imm;
      mie_pkg::MIE_OP_COPY_MEM_TO_ACC:   result = mem;
      mie_pkg::MIE_OP_COPY_ACC_TO_MEM:   result = acc;
      mie_pkg::MIE_OP_UNION_MEM,
      mie_pkg::MIE_OP_UNION_TO_MEM:      result = acc | mem;
      mie_pkg::MIE_OP_UNION_IMM:         result = acc | imm;
      mie_pkg::MIE_OP_ROTATE_LEFT,
      mie_pkg::MIE_OP_ROTATE_LEFT_TO_ACC: result = {mem[6:0], mem[7]};
      default:                           result = acc;
    endcase
    if (!op_is_valid) begin
      result = acc;
    end
  end

  assign result_zero = (result == mie_pkg::BYTE_ZERO);

endmodule
`default_nettype wire

// file: logic/mie_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Both pre-clears executed clear watchdog counter, timeout and powerdown flags.
// - A single pre-clear only marks itself; watchdog and flags stay unchanged.
// - Invert memory writes ones' complement back, updates only zero.
// - Invert to accumulator loads complement, memory untouched, only zero updated.
// - BCD low nibble adds 6 when above 9 or half carry set.
// - BCD high nibble plus nibble carry adds 6, sets carry, above 9 or carry.
// - Minus-one to memory or accumulator, updates only zero.
// - Plus-one to memory or accumulator, updates only zero.
// - Sleep stops execution and clock, keeps state, advances counter.
// - Sleep clears watchdog and prescaler, sets powerdown, clears timeout.
// - Direct branch loads program counter from instruction, flags untouched.
// - Immediate copy loads 8-bit constant into accumulator, no flag changes.
// - Copies between memory and accumulator leave every flag unaffected.
// - Union ORs accumulator with byte or immediate, updates only zero.
// - Idle advances program counter by one, flags unchanged.
// - Subroutine exit reloads counter from stack top, takes two cycles.
// - Value exit reloads counter from stack, loads immediate into accumulator.
// - Interrupt exit reloads counter from stack, sets global enable.
// - Rotate left moves bit 7 into bit 0, writes back, flags unchanged.
// - Rotate left to accumulator, memory unchanged, no flag affected.
// - Instruction cycle is four clocks; low counter byte load adds one cycle.
module mie_exec #(
  parameter int unsigned     PC_W     = mie_pkg::PC_W,
  parameter logic [7:0]      PCL_ADDR = mie_pkg::PCL_ADDR_DEF
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             instr_valid,
  output logic                  instr_ready,
  input  wire mie_pkg::mie_op_t instr_op,
  input  wire logic [7:0]       instr_addr,
  input  wire logic [7:0]       instr_imm,
  input  wire logic [PC_W-1:0]  instr_target,
  output logic                  instr_done,
  output logic [7:0]            mem_addr,
  input  wire logic [7:0]       mem_rdata,
  output logic                  mem_we,
  output logic [7:0]            mem_wdata,
  input  wire logic [PC_W-1:0]  stack_top,
  output logic                  stack_pop,
  output logic [PC_W-1:0]       pc,
  output logic [7:0]            acc,
  output logic                  zero_flag,
  output logic                  carry_flag,
  input  wire logic             half_carry_flag,
  output logic                  watchdog_timeout_flag,
  output logic                  powerdown_flag,
  output logic                  global_irq_enable,
  input  wire logic             wdt_timeout,
  input  wire logic             irq_taken,
  output logic                  wdt_clear,
  output logic                  prescaler_clear,
  output logic                  sys_clk_stop,
  input  wire logic             wake,
  output logic                  preclear_a_seen,
  output logic                  preclear_b_seen
);

  //////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Operations whose result is written back to the addressed byte
  function automatic logic op_writes_mem(input mie_pkg::mie_op_t op);
    case (op)
      mie_pkg::MIE_OP_INVERT_MEM,
      mie_pkg::MIE_OP_BCD_ADJUST,
      mie_pkg::MIE_OP_MINUS_ONE_MEM,
      mie_pkg::MIE_OP_PLUS_ONE_MEM,
      mie_pkg::MIE_OP_COPY_ACC_TO_MEM,
      mie_pkg::MIE_OP_UNION_TO_MEM,
      mie_pkg::MIE_OP_ROTATE_LEFT:  return 1'b1;
      default:                      return 1'b0;
    endcase
  endfunction

  // Operations whose result lands in the accumulator
  function automatic logic op_writes_acc(input mie_pkg::mie_op_t op);
    case (op)
      mie_pkg::MIE_OP_INVERT_TO_ACC,
      mie_pkg::MIE_OP_MINUS_ONE_TO_ACC,
      mie_pkg::MIE_OP_PLUS_ONE_TO_ACC,
      mie_pkg::MIE_OP_COPY_IMM,
      mie_pkg::MIE_OP_COPY_MEM_TO_ACC,
      mie_pkg::MIE_OP_UNION_MEM,
      mie_pkg::MIE_OP_UNION_IMM,
      mie_pkg::MIE_OP_SUBROUTINE_EXIT_VAL,
      mie_pkg::MIE_OP_ROTATE_LEFT_TO_ACC: return 1'b1;
      default:                            return 1'b0;
    endcase
  endfunction

  // Operations that update the zero flag and nothing else
  function automatic logic op_sets_zero(input mie_pkg::mie_op_t op);
    case (op)
      mie_pkg::MIE_OP_INVERT_MEM,
      mie_pkg::MIE_OP_INVERT_TO_ACC,
      mie_pkg::MIE_OP_MINUS_ONE_MEM,
      mie_pkg::MIE_OP_MINUS_ONE_TO_ACC,
      mie_pkg::MIE_OP_PLUS_ONE_MEM,
      mie_pkg::MIE_OP_PLUS_ONE_TO_ACC,
      mie_pkg::MIE_OP_UNION_MEM,
      mie_pkg::MIE_OP_UNION_IMM,
      mie_pkg::MIE_OP_UNION_TO_MEM: return 1'b1;
      default:                      return 1'b0;
    endcase
  endfunction

  // Operations that fetch their successor from the stack or branch target
  function automatic logic op_two_cycle(input mie_pkg::mie_op_t op);
    case (op)
      mie_pkg::MIE_OP_DIRECT_BRANCH,
      mie_pkg::MIE_OP_SUBROUTINE_EXIT,
      mie_pkg::MIE_OP_SUBROUTINE_EXIT_VAL,
      mie_pkg::MIE_OP_INTERRUPT_EXIT: return 1'b1;
      default:                        return 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State

  mie_pkg::mie_state_t state_r;
  mie_pkg::mie_state_t state_nxt;
  mie_pkg::mie_op_t    op_r;
  mie_pkg::mie_op_t    op_nxt;
  logic [7:0]          imm_r;
  logic [7:0]          imm_nxt;
  logic [PC_W-1:0]     target_r;
  logic [PC_W-1:0]     target_nxt;
  logic [7:0]          mem_addr_r;
  logic [7:0]          mem_addr_nxt;
  logic                mem_we_r;
  logic                mem_we_nxt;
  logic [7:0]          mem_wdata_r;
  logic [7:0]          mem_wdata_nxt;
  logic                stack_pop_r;
  logic                stack_pop_nxt;
  logic [PC_W-1:0]     pc_r;
  logic [PC_W-1:0]     pc_nxt;
  logic [7:0]          acc_r;
  logic [7:0]          acc_nxt;
  logic                zero_r;
  logic                zero_nxt;
  logic                carry_r;
  logic                carry_nxt;
  logic                tmo_r;
  logic                tmo_nxt;
  logic                pdn_r;
  logic                pdn_nxt;
  logic                gie_r;
  logic                gie_nxt;
  logic                pre_a_r;
  logic                pre_a_nxt;
  logic                pre_b_r;
  logic                pre_b_nxt;
  logic                wdt_clr_r;
  logic                wdt_clr_nxt;
  logic                psc_clr_r;
  logic                psc_clr_nxt;
  logic                done_r;
  logic                done_nxt;

  logic                run;
  logic                cycle_end;
  logic [7:0]          alu_result;
  logic                alu_zero;
  logic                alu_carry;
  logic                pcl_hit;

  //////////////////////////////////////////////////////////////////////////
  // Instruction cycle timing: one enable pulse per four system clocks
  assign run = (state_r == mie_pkg::MIE_ST_EXEC) || (state_r == mie_pkg::MIE_ST_EXTRA);

  mie_phase_div #(
    .CLKS (mie_pkg::CLKS_PER_CYCLE)
  ) mie_phase_div_inst (
    .clk       (clk),
    .srst      (srst),
    .run       (run),
    .cycle_end (cycle_end)
  );

  mie_alu mie_alu_inst (
    .op_is_valid (state_r == mie_pkg::MIE_ST_EXEC),
    .op          (op_r),
    .acc         (acc_r),
    .mem         (mem_rdata),
    .imm         (imm_r),
    .half_carry  (half_carry_flag),
    .carry       (carry_r),
    .result      (alu_result),
    .result_zero (alu_zero),
    .carry_out   (alu_carry)
  );

  // A write to the low counter byte also reloads counter bits 7:0
  assign pcl_hit = op_writes_mem(op_r) && (mem_addr_r == PCL_ADDR);

  //////////////////////////////////////////////////////////////////////////
  // Sequencer and commit
  always_comb begin
    state_nxt     = state_r;
    op_nxt        = op_r;
    imm_nxt       = imm_r;
    target_nxt    = target_r;
    mem_addr_nxt  = mem_addr_r;
    mem_we_nxt    = 1'b0;
    mem_wdata_nxt = mem_wdata_r;
    stack_pop_nxt = 1'b0;
    pc_nxt        = pc_r;
    acc_nxt       = acc_r;
    zero_nxt      = zero_r;
    carry_nxt     = carry_r;
    tmo_nxt       = tmo_r;
    pdn_nxt       = pdn_r;
    gie_nxt       = gie_r;
    pre_a_nxt     = pre_a_r;
    pre_b_nxt     = pre_b_r;
    wdt_clr_nxt   = 1'b0;
    psc_clr_nxt   = 1'b0;
    done_nxt      = 1'b0;

    // Interrupt acceptance drops the global enable unless an interrupt exit commits in the same cycle
    if (irq_taken) begin
      gie_nxt = 1'b0;
    end

    unique case (state_r)
      mie_pkg::MIE_ST_READY: begin
        if (instr_valid) begin
          op_nxt       = instr_op;
          imm_nxt      = instr_imm;
          target_nxt   = instr_target;
          mem_addr_nxt = instr_addr;
          state_nxt    = mie_pkg::MIE_ST_EXEC;
        end
      end

      mie_pkg::MIE_ST_EXEC: begin
        if (cycle_end) begin
          pc_nxt = pc_r + 1'b1;
          if (op_writes_mem(op_r)) begin
            mem_we_nxt    = 1'b1;
            mem_wdata_nxt = alu_result;
          end
          if (op_writes_acc(op_r)) begin
            acc_nxt = alu_result;
          end
          if (op_sets_zero(op_r)) begin
            zero_nxt = alu_zero;
          end
          unique case (op_r)
            mie_pkg::MIE_OP_PRECLEAR_A: begin
              if (pre_b_r) begin
                pre_a_nxt   = 1'b0;
                pre_b_nxt   = 1'b0;
                wdt_clr_nxt = 1'b1;
                tmo_nxt     = 1'b0;
                pdn_nxt     = 1'b0;
              end else begin
                pre_a_nxt   = 1'b1;
              end
            end
            mie_pkg::MIE_OP_PRECLEAR_B: begin
              if (pre_a_r) begin
                pre_a_nxt   = 1'b0;
                pre_b_nxt   = 1'b0;
                wdt_clr_nxt = 1'b1;
                tmo_nxt     = 1'b0;
                pdn_nxt     = 1'b0;
              end else begin
                pre_b_nxt   = 1'b1;
              end
            end
            mie_pkg::MIE_OP_BCD_ADJUST: begin
              carry_nxt = alu_carry;
            end
            mie_pkg::MIE_OP_SLEEP: begin
              wdt_clr_nxt = 1'b1;
              psc_clr_nxt = 1'b1;
              pdn_nxt     = 1'b1;
              tmo_nxt     = 1'b0;
            end
            mie_pkg::MIE_OP_DIRECT_BRANCH: begin
              pc_nxt = target_r;
            end
            mie_pkg::MIE_OP_SUBROUTINE_EXIT,
            mie_pkg::MIE_OP_SUBROUTINE_EXIT_VAL: begin
              pc_nxt        = stack_top;
              stack_pop_nxt = 1'b1;
            end
            mie_pkg::MIE_OP_INTERRUPT_EXIT: begin
              pc_nxt        = stack_top;
              stack_pop_nxt = 1'b1;
              gie_nxt       = 1'b1;
            end
            default: begin
            end
          endcase
          if (pcl_hit) begin
            pc_nxt[7:0] = alu_result;
          end
          // Sleep holds the clock until wake; counter already advanced
          if (op_r == mie_pkg::MIE_OP_SLEEP) begin
            state_nxt = mie_pkg::MIE_ST_SLEEP;
          end else if (op_two_cycle(op_r) || pcl_hit) begin
            state_nxt = mie_pkg::MIE_ST_EXTRA;
          end else begin
            state_nxt = mie_pkg::MIE_ST_READY;
            done_nxt  = 1'b1;
          end
        end
      end

      mie_pkg::MIE_ST_EXTRA: begin
        if (cycle_end) begin
          state_nxt = mie_pkg::MIE_ST_READY;
          done_nxt  = 1'b1;
        end
      end

      mie_pkg::MIE_ST_SLEEP: begin
        if (wake) begin
          state_nxt = mie_pkg::MIE_ST_READY;
          done_nxt  = 1'b1;
        end
      end
    endcase

    // A timeout in the same cycle as a clear still lands
    if (wdt_timeout) begin
      tmo_nxt = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r     <= mie_pkg::MIE_ST_READY;
      op_r        <= mie_pkg::MIE_OP_IDLE;
      imm_r       <= 8'h00;
      target_r    <= '0;
      mem_addr_r  <= 8'h00;
      mem_we_r    <= 1'b0;
      mem_wdata_r <= 8'h00;
      stack_pop_r <= 1'b0;
      pc_r        <= '0;
      acc_r       <= mie_pkg::ACC_RST;
      zero_r      <= mie_pkg::ZERO_RST;
      carry_r     <= mie_pkg::CARRY_RST;
      tmo_r       <= mie_pkg::TMO_RST;
      pdn_r       <= mie_pkg::PDN_RST;
      gie_r       <= mie_pkg::GIE_RST;
      pre_a_r     <= 1'b0;
      pre_b_r     <= 1'b0;
      wdt_clr_r   <= 1'b0;
      psc_clr_r   <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      op_r        <= op_nxt;
      imm_r       <= imm_nxt;
      target_r    <= target_nxt;
      mem_addr_r  <= mem_addr_nxt;
      mem_we_r    <= mem_we_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      stack_pop_r <= stack_pop_nxt;
      pc_r        <= pc_nxt;
      acc_r       <= acc_nxt;
      zero_r      <= zero_nxt;
      carry_r     <= carry_nxt;
      tmo_r       <= tmo_nxt;
      pdn_r       <= pdn_nxt;
      gie_r       <= gie_nxt;
      pre_a_r     <= pre_a_nxt;
      pre_b_r     <= pre_b_nxt;
      wdt_clr_r   <= wdt_clr_nxt;
      psc_clr_r   <= psc_clr_nxt;
      done_r      <= done_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs; ready is combinational so decode can issue back to back
  assign instr_ready           = (state_r == mie_pkg::MIE_ST_READY);
  assign instr_done            = done_r;
  assign mem_addr              = mem_addr_r;
  assign mem_we                = mem_we_r;
  assign mem_wdata             = mem_wdata_r;
  assign stack_pop             = stack_pop_r;
  assign pc                    = pc_r;
  assign acc                   = acc_r;
  assign zero_flag             = zero_r;
  assign carry_flag            = carry_r;
  assign watchdog_timeout_flag = tmo_r;
  assign powerdown_flag        = pdn_r;
  assign global_irq_enable     = gie_r;
  assign wdt_clear             = wdt_clr_r;
  assign prescaler_clear       = psc_clr_r;
  assign sys_clk_stop          = (state_r == mie_pkg::MIE_ST_SLEEP);
  assign preclear_a_seen       = pre_a_r;
  assign preclear_b_seen       = pre_b_r;

endmodule
`default_nettype wire

// file: bench/mie_exec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mie_exec_asserts (
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             instr_valid,
  input wire logic             instr_ready,
  input wire mie_pkg::mie_op_t instr_op,
  input wire logic             instr_done,
  input wire logic             mem_we,
  input wire logic             stack_pop,
  input wire logic             zero_flag,
  input wire logic             watchdog_timeout_flag,
  input wire logic             powerdown_flag,
  input wire logic             wdt_clear,
  input wire logic             prescaler_clear,
  input wire logic             sys_clk_stop,
  input wire logic             preclear_b_seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Issue edge of a request
  logic iss;
  assign iss = instr_valid && instr_ready;
  ////////////////////////////////////////////////////////////////////////////////
  property p_cyc;
    iss && instr_op == mie_pkg::MIE_OP_IDLE |=> !instr_ready [*4] ##1 instr_done;
  endproperty
  a_cyc: assert property (p_cyc) else $error("idle length wrong");
  property p_two;
    iss && instr_op == mie_pkg::MIE_OP_SUBROUTINE_EXIT |=> !instr_done [*8] ##1 instr_done;
  endproperty
  a_two: assert property (p_two) else $error("exit length wrong");
  property p_pop;
    iss && instr_op == mie_pkg::MIE_OP_SUBROUTINE_EXIT_VAL |-> ##[5:9] stack_pop;
  endproperty
  a_pop: assert property (p_pop) else $error("no stack pop");
  property p_slp;
    iss && instr_op == mie_pkg::MIE_OP_SLEEP |-> ##5 sys_clk_stop && powerdown_flag
      && !watchdog_timeout_flag && wdt_clear && prescaler_clear;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep entry wrong");
  // Pair completed by A: watchdog and both flags clear
  property p_clr;
    iss && instr_op == mie_pkg::MIE_OP_PRECLEAR_A && preclear_b_seen |-> ##5 wdt_clear
      && !watchdog_timeout_flag && !powerdown_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("pair did not clear");
  property p_one;
    iss && instr_op == mie_pkg::MIE_OP_PRECLEAR_A && !preclear_b_seen |-> ##5 !wdt_clear
      && $stable(powerdown_flag);
  endproperty
  a_one: assert property (p_one) else $error("single cleared");
  property p_acc;
    iss && instr_op == mie_pkg::MIE_OP_INVERT_TO_ACC |=> !mem_we [*5];
  endproperty
  a_acc: assert property (p_acc) else $error("memory written");
  property p_we;
    iss && instr_op == mie_pkg::MIE_OP_INVERT_MEM |-> ##5 mem_we;
  endproperty
  a_we: assert property (p_we) else $error("no write back");
  property p_zf;
    iss && instr_op == mie_pkg::MIE_OP_COPY_IMM |-> ##5 $stable(zero_flag);
  endproperty
  a_zf: assert property (p_zf) else $error("flag changed");
  c_slp: cover property (iss && instr_op == mie_pkg::MIE_OP_SLEEP);
  c_clr: cover property (wdt_clear && !sys_clk_stop);
  c_pop: cover property (stack_pop);
endmodule
bind mie_exec mie_exec_asserts mie_exec_asserts_inst (.*);
`default_nettype wire

// file: bench/mie_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mie_mem_model (
  input  wire logic                   clk,
  input  wire logic [7:0]             mem_addr,
  output logic [7:0]                  mem_rdata,
  input  wire logic                   mem_we,
  input  wire logic [7:0]             mem_wdata,
  output logic [mie_pkg::PC_W-1:0]    stack_top,
  input  wire logic                   stack_pop
);
  logic [7:0]               ram [256];
  logic [mie_pkg::PC_W-1:0] top_r;
  // Byte and return address presented without delay
  assign mem_rdata = ram[mem_addr];
  assign stack_top = top_r;
  // A pop garbles the old entry, so a stale reload cannot pass
  always @(posedge clk) begin
    if (mem_we) ram[mem_addr] <= mem_wdata;
    if (stack_pop) top_r <= ~top_r;
  end
endmodule
`default_nettype wire

// file: bench/mie_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mie_exec_bench;
  logic clk = 0, srst = 1, instr_valid = 0, half_carry_flag = 0;
  logic wdt_timeout = 0, irq_taken = 0, wake = 0;
  mie_pkg::mie_op_t instr_op = mie_pkg::MIE_OP_IDLE;
  logic [7:0] instr_addr = 8'h00, instr_imm = 8'h00, mem_addr, mem_rdata, mem_wdata, acc;
  logic [11:0] instr_target = 12'h000, stack_top, pc, p;
  logic instr_ready, instr_done, mem_we, stack_pop, zero_flag, carry_flag, wdt_clear;
  logic watchdog_timeout_flag, powerdown_flag, global_irq_enable, prescaler_clear;
  logic sys_clk_stop, preclear_a_seen, preclear_b_seen;
  int err_total = 0, comparisons = 0;
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  mie_exec mie_exec_inst (.*);
  mie_mem_model mdl (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count; unknowns never match
  task automatic ck(logic [11:0] s, logic [11:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results;
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Issue one instruction, wait for done and for the write to land
  task automatic op(mie_pkg::mie_op_t o, logic [7:0] a = 8'h00, logic [7:0] x = 8'h00);
    int n = 0;
    @(negedge clk);
    instr_op = o;
    instr_addr = a;
    instr_imm = x;
    instr_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    instr_valid = 1'b0;
    while (instr_done !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n == 60) err_total++;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    mdl.ram[8'h0A] = 8'h9A;
    mdl.ram[8'h0C] = 8'hFF;
    mdl.ram[8'h0D] = 8'h01;
    mdl.ram[8'h0F] = 8'h81;
    op(mie_pkg::MIE_OP_COPY_MEM_TO_ACC, 8'h0A); ck(acc, 8'h9A);
    op(mie_pkg::MIE_OP_BCD_ADJUST, 8'h0B); ck(mdl.ram[8'h0B], 8'h00);
    ck(carry_flag, 1'b1);
    half_carry_flag = 1'b1;
    op(mie_pkg::MIE_OP_COPY_IMM, 8'h00, 8'h15); ck(acc, 8'h15);
    op(mie_pkg::MIE_OP_BCD_ADJUST, 8'h0B); ck(mdl.ram[8'h0B], 8'h7B);
    half_carry_flag = 1'b0;
    op(mie_pkg::MIE_OP_INVERT_TO_ACC, 8'h0A); ck(acc, 8'h65);
    op(mie_pkg::MIE_OP_PLUS_ONE_MEM, 8'h0C); ck(zero_flag, 1'b1);
    op(mie_pkg::MIE_OP_INVERT_MEM, 8'h0A); ck(mdl.ram[8'h0A], 8'h65);
    ck(zero_flag, 1'b0);
    op(mie_pkg::MIE_OP_MINUS_ONE_TO_ACC, 8'h0C); ck(acc, 8'hFF);
    op(mie_pkg::MIE_OP_MINUS_ONE_MEM, 8'h0D); ck(zero_flag, 1'b1);
    op(mie_pkg::MIE_OP_PLUS_ONE_TO_ACC, 8'h0A); ck(acc, 8'h66);
    op(mie_pkg::MIE_OP_COPY_ACC_TO_MEM, 8'h0E); ck(mdl.ram[8'h0E], 8'h66);
    op(mie_pkg::MIE_OP_UNION_IMM, 8'h00, 8'h81); ck(acc, 8'hE7);
    op(mie_pkg::MIE_OP_UNION_TO_MEM, 8'h0D); ck(mdl.ram[8'h0D], 8'hE7);
    op(mie_pkg::MIE_OP_UNION_MEM, 8'h0C); ck(zero_flag, 1'b0);
    op(mie_pkg::MIE_OP_ROTATE_LEFT, 8'h0F); ck(mdl.ram[8'h0F], 8'h03);
    op(mie_pkg::MIE_OP_ROTATE_LEFT_TO_ACC, 8'h0A); ck(acc, 8'hCA);
    ck(mdl.ram[8'h0A], 8'h65);
    p = pc;
    op(mie_pkg::MIE_OP_IDLE); ck(pc, p + 12'h001);
    instr_target = 12'hA5C;
    op(mie_pkg::MIE_OP_DIRECT_BRANCH); ck(pc, 12'hA5C);
    ck(carry_flag, 1'b1);
    mdl.top_r = 12'h3F1;
    op(mie_pkg::MIE_OP_SUBROUTINE_EXIT); ck(pc, 12'h3F1);
    mdl.top_r = 12'h2E7;
    op(mie_pkg::MIE_OP_SUBROUTINE_EXIT_VAL, 8'h00, 8'h5E); ck(pc, 12'h2E7);
    ck(acc, 8'h5E);
    pulse(irq_taken);
    op(mie_pkg::MIE_OP_INTERRUPT_EXIT); ck(global_irq_enable, 1'b1);
    // Write to the low counter byte redirects the program
    op(mie_pkg::MIE_OP_COPY_IMM, 8'h00, 8'h3C);
    op(mie_pkg::MIE_OP_COPY_ACC_TO_MEM, mie_pkg::PCL_ADDR_DEF); ck(pc[7:0], 8'h3C);
    // Sleep with a pending timeout; wake comes later from a side process
    pulse(wdt_timeout);
    fork
      begin
        repeat (20) @(negedge clk);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
      end
    join_none
    p = pc;
    op(mie_pkg::MIE_OP_SLEEP); ck(pc, p + 12'h001);
    ck(powerdown_flag, 1'b1);
    ck(watchdog_timeout_flag, 1'b0);
    // Repeated A never clears; B completes the pair
    pulse(wdt_timeout);
    op(mie_pkg::MIE_OP_PRECLEAR_A); ck(preclear_a_seen, 1'b1);
    op(mie_pkg::MIE_OP_PRECLEAR_A);
    op(mie_pkg::MIE_OP_IDLE); ck(watchdog_timeout_flag, 1'b1);
    op(mie_pkg::MIE_OP_PRECLEAR_B); ck(powerdown_flag, 1'b0);
    ck(watchdog_timeout_flag, 1'b0);
    ck(preclear_a_seen, 1'b0);
    pulse(wdt_timeout);
    op(mie_pkg::MIE_OP_PRECLEAR_B);
    op(mie_pkg::MIE_OP_PRECLEAR_A); ck(watchdog_timeout_flag, 1'b0);
    results();
  end
endmodule
`default_nettype wire
